//--- rtl/rws_pkg.sv
/*
 * Constants for the reset and wake-up sequencer: register layouts, reset
 * values, hold and wake times, oscillator modes and the register map.
 * Assumes a 100 MHz system clock and a 32-bit Avalon-MM register bus.
 */
package rws_pkg;

   // Clock rate.
   localparam int unsigned CLK_HZ            = 100_000_000;

   // Reset hold and oscillator wake-up times, in their printed units.
   localparam int unsigned HOLD_NORMAL_MS    = 18;
   localparam int unsigned HOLD_LXT_MS       = 500;
   localparam int unsigned WAKE_RC_US        = 10;
   localparam int unsigned WAKE_HXT_US       = 800;
   localparam int unsigned WAKE_LXT_MIN_S    = 2;

   // Cycle counts derived from the times above.
   localparam longint unsigned HOLD_NORMAL_CYC = longint'(HOLD_NORMAL_MS) * CLK_HZ / 1000;
   localparam longint unsigned HOLD_LXT_CYC    = longint'(HOLD_LXT_MS) * CLK_HZ / 1000;
   localparam longint unsigned WAKE_RC_CYC     = longint'(WAKE_RC_US) * CLK_HZ / 1_000_000;
   localparam longint unsigned WAKE_HXT_CYC    = longint'(WAKE_HXT_US) * CLK_HZ / 1_000_000;
   localparam longint unsigned WAKE_LXT_CYC    = longint'(WAKE_LXT_MIN_S) * CLK_HZ;

   localparam int CNT_W = 32;

   // Oscillator modes.
   typedef enum logic [1:0]
   {
      OSC_RC   = 2'h0,
      OSC_HXT  = 2'h1,
      OSC_LXT  = 2'h2
   } rws_osc_t;

   // Widths.
   localparam int PC_W   = 11;
   localparam int REG_W  = 8;
   localparam logic [PC_W-1:0] PC_RESET  = 11'h000;
   localparam logic [PC_W-1:0] PC_VECTOR = 11'h008;

   // Reset values of the controlled registers.
   localparam logic [REG_W-1:0] ALL_ZERO       = 8'h00;
   localparam logic [REG_W-1:0] ALL_ONE        = 8'hFF;
   localparam logic [REG_W-1:0] TIMER_KEEP_MSK = 8'h40;
   localparam int               TIMER_IRQ_BIT  = 6;

   // Control register fields.
   localparam int CTL_WDT_EN    = 0;
   localparam int CTL_PORT_WAKE = 1;
   localparam int CTL_CMP_WAKE  = 2;
   localparam int CTL_GIE       = 3;
   localparam int CTL_OSC_LO    = 4;

   // Status register fields.
   localparam int ST_TIMEOUT  = 0;
   localparam int ST_PWRDN    = 1;
   localparam int ST_ASLEEP   = 2;
   localparam int ST_INRESET  = 3;
   localparam int ST_WAKING   = 4;

   // Register map, byte addresses.
   localparam logic [7:0] ADDR_CTRL    = 8'h00;
   localparam logic [7:0] ADDR_STATUS  = 8'h04;
   localparam logic [7:0] ADDR_TIMER   = 8'h08;
   localparam logic [7:0] ADDR_MEMSW   = 8'h0C;
   localparam logic [7:0] ADDR_IRQFLG  = 8'h10;
   localparam logic [7:0] ADDR_WDTCTL  = 8'h14;
   localparam logic [7:0] ADDR_IRQEN   = 8'h18;
   localparam logic [7:0] ADDR_PULLHI  = 8'h1C;
   localparam logic [7:0] ADDR_PULLDN  = 8'h20;
   localparam logic [7:0] ADDR_ODRAIN  = 8'h24;
   localparam logic [7:0] ADDR_IODIR   = 8'h28;

   localparam logic [31:0] BUS_UNMAPPED = 32'h0000_0000;

   // Sequencer states.
   typedef enum logic [4:0]
   {
      ST_HOLD  = 5'b0_0001,
      ST_RUN   = 5'b0_0010,
      ST_SLEEP = 5'b0_0100,
      ST_WAKE  = 5'b0_1000,
      ST_RESUME = 5'b1_0000
   } rws_state_t;

endpackage : rws_pkg

//--- rtl/rws_counter.sv
/*
 * Loadable down-counter that flags when it has run out.
 * Assumes one clock and an asynchronous active-high reset.
 */
`timescale 1ns/100ps
`default_nettype none
module rws_counter
   import rws_pkg::*;
(
   // Clock and reset.
   input  wire logic             clk,
   input  wire logic             rst,
   // Control.
   input  wire logic             load,
   input  wire logic [CNT_W-1:0] load_val,
   input  wire logic             run,
   // Status.
   output logic                  done
);

   logic [CNT_W-1:0] cnt_r;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         cnt_r <= '0;
      else if (load)
         cnt_r <= load_val;
      else if (run && cnt_r != '0)
         cnt_r <= cnt_r - 1'b1;
   end

   assign done = (cnt_r == '0) && !load;

endmodule : rws_counter
`default_nettype wire

//--- rtl/rws_sequencer.sv
/*
 * Reset and sleep/wake-up sequencer of an 8-bit microcontroller core, with
 * its controlled registers reachable over Avalon-MM.
 * Assumes the core reports the sleep and interrupt instructions as pulses and
 * that all inputs are synchronous to clk.
 */
//
// How it works
// R1 - Power-on, low reset pin, watchdog timeout reset
// R2 - Hold reset about 18 ms
// R3 - Low-frequency crystal: hold 500 ms
// R4 - Program counter cleared on reset
// R5 - All port pins become inputs
// R6 - Watchdog and prescaler cleared on reset
// R7 - Oscillator runs or restarts on reset
// R8 - Memory switch cleared only at power-up
// R9 - Timer control cleared except bit 6
// R10 - Flag, watchdog control, enable registers cleared
// R11 - Pull-high, pull-down, open-drain set all ones
// R12 - Sleep stops oscillator and timer
// R13 - Enabled watchdog cleared, keeps running asleep
// R14 - Wake on pin, watchdog, port, comparator
// R15 - Pin/watchdog wake resets; flags record cause
// R16 - Interrupts on: resume at vector
// R17 - Interrupts off: resume after sleep
// R18 - Watchdog enabled masks wake enables
// R19 - Firmware disables watchdog for port wake
// R20 - Firmware disables watchdog for comparator wake
// R21 - Wake delay 10 us RC, 800 us HXT
// R22 - Low-frequency crystal wake delay 2-3 s
// R23 - Firmware port-wake preparation sequence
// R24 - Firmware comparator-wake preparation sequence
// R25 - Watchdog or low voltage resets any mode
`timescale 1ns/100ps
`default_nettype none
module rws_sequencer
   import rws_pkg::*;
#(
   parameter longint unsigned HOLD_NORMAL = HOLD_NORMAL_CYC,
   parameter longint unsigned HOLD_LXT    = HOLD_LXT_CYC,
   parameter longint unsigned WAKE_RC     = WAKE_RC_CYC,
   parameter longint unsigned WAKE_HXT    = WAKE_HXT_CYC,
   parameter longint unsigned WAKE_LXT    = WAKE_LXT_CYC
)
(
   // Clock and power-on reset.
   input  wire logic              clk,
   input  wire logic              rst,
   // Reset sources.
   input  wire logic              reset_pin_n,
   input  wire logic              low_voltage,
   input  wire logic              wdt_timeout,
   // Core events.
   input  wire logic              power_down_instr,
   input  wire logic              global_irq_on_instr,
   input  wire logic              global_irq_off_instr,
   input  wire logic              port_change,
   input  wire logic              comparator_change,
   // Core control.
   output logic                   core_reset,
   output logic                   osc_run,
   output logic                   timer_run,
   output logic                   wdt_clear,
   output logic                   pc_load,
   output logic [PC_W-1:0]        pc_value,
   output logic [REG_W-1:0]       port_dir_in,
   // Avalon-MM slave.
   input  wire logic [7:0]        avs_address,
   input  wire logic              avs_read,
   input  wire logic              avs_write,
   input  wire logic [31:0]       avs_writedata,
   output logic [31:0]            avs_readdata,
   output logic                   avs_waitrequest
);

   ////////////////////////////////////////////////////////////////////////////

   rws_state_t       state_r;
   logic [7:0]       ctrl_r;
   logic [7:0]       timer_ctrl_reg_r;
   logic [7:0]       memory_switch_reg_r;
   logic [7:0]       irq_flag_r;
   logic [7:0]       wdt_ctrl_r;
   logic [7:0]       irq_en_r;
   logic [7:0]       pull_high_ctrl_reg_r;
   logic [7:0]       pull_down_ctrl_reg_r;
   logic [7:0]       odrain_r;
   logic [7:0]       iodir_r;
   logic             timeout_flag_r;
   logic             pwrdn_flag_r;
   logic             gie_r;
   logic             ack_r;
   logic             cnt_load;
   logic [CNT_W-1:0] cnt_val;
   logic             cnt_done;
   logic             reset_req;
   logic             wdt_on;
   logic             soft_wake;
   logic             wr;
   logic             rd;
   logic             por_r;
   rws_osc_t         osc_mode;

   assign osc_mode  = rws_osc_t'(ctrl_r[CTL_OSC_LO+1:CTL_OSC_LO]);
   assign wdt_on    = ctrl_r[CTL_WDT_EN];
   // A watchdog timeout only counts while the watchdog is enabled.
   assign reset_req = !reset_pin_n || low_voltage || (wdt_on && wdt_timeout); // R1 R25
   // With the watchdog on, the port and comparator wake enables are ignored.
   assign soft_wake = !wdt_on &&                                            // R18
                      ((ctrl_r[CTL_PORT_WAKE] && port_change) ||
                       (ctrl_r[CTL_CMP_WAKE] && comparator_change));         // R14

   ////////////////////////////////////////////////////////////////////////////
   // Delay counter shared by reset hold and oscillator wake-up.

   always_comb
   begin
      cnt_load = 1'b0;
      cnt_val  = CNT_W'(HOLD_NORMAL);                                      // R2
      // Power-on is a detected reset too, so it gets the full hold time.
      if (reset_req || por_r)
      begin
         cnt_load = 1'b1;
         cnt_val  = (osc_mode == OSC_LXT) ? CNT_W'(HOLD_LXT)                // R3
                                          : CNT_W'(HOLD_NORMAL);
      end
      else if (state_r == ST_SLEEP && soft_wake)
      begin
         cnt_load = 1'b1;
         case (osc_mode)
            OSC_RC:  cnt_val = CNT_W'(WAKE_RC);                            // R21
            OSC_HXT: cnt_val = CNT_W'(WAKE_HXT);                           // R21
            default: cnt_val = CNT_W'(WAKE_LXT);                           // R22
         endcase
      end
   end

   // High for the first cycle after power-on reset only.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         por_r <= 1'b1;
      else
         por_r <= 1'b0;                                                    // R2
   end

   rws_counter u_delay
   (
      .clk      (clk),
      .rst      (rst),
      .load     (cnt_load),
      .load_val (cnt_val),
      .run      (1'b1),
      .done     (cnt_done)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer state.

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         state_r <= ST_HOLD;
      else if (reset_req)
         state_r <= ST_HOLD;                                               // R15
      else
      begin
         case (state_r)
            ST_HOLD:   if (cnt_done) state_r <= ST_RUN;
            ST_RUN:    if (power_down_instr) state_r <= ST_SLEEP;          // R12
            ST_SLEEP:  if (soft_wake) state_r <= ST_WAKE;
            ST_WAKE:   if (cnt_done) state_r <= ST_RESUME;
            ST_RESUME: state_r <= ST_RUN;
            default:   state_r <= ST_HOLD;
         endcase
      end
   end

   // Global interrupt state as set by the last on/off instruction.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         gie_r <= 1'b0;
      else if (global_irq_on_instr)
         gie_r <= 1'b1;
      else if (global_irq_off_instr)
         gie_r <= 1'b0;
   end

   // Cause flags: timeout set on watchdog reset, power-down set on sleep.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         timeout_flag_r <= 1'b0;
         pwrdn_flag_r   <= 1'b0;
      end
      else if (wdt_on && wdt_timeout)
      begin
         timeout_flag_r <= 1'b1;                                           // R15
         pwrdn_flag_r   <= (state_r == ST_SLEEP);                          // R15
      end
      else if (!reset_pin_n)
      begin
         timeout_flag_r <= 1'b0;                                           // R15
         pwrdn_flag_r   <= (state_r == ST_SLEEP) || pwrdn_flag_r;          // R15
      end
      else if (state_r == ST_RUN && power_down_instr)
         pwrdn_flag_r   <= 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Core control outputs.

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         core_reset <= 1'b1;
         osc_run    <= 1'b1;
         timer_run  <= 1'b0;
         wdt_clear  <= 1'b1;
         pc_load    <= 1'b1;
         pc_value   <= PC_RESET;
      end
      else
      begin
         core_reset <= reset_req || (state_r == ST_HOLD && !cnt_done);
         // Oscillator restarts on reset or wake, stops in sleep.
         osc_run    <= reset_req || (state_r != ST_SLEEP) ||
                       soft_wake;                                          // R7 R12
         timer_run  <= !reset_req && (state_r == ST_RUN) && !power_down_instr; // R12
         wdt_clear  <= reset_req || (state_r == ST_RUN && power_down_instr); // R6 R13
         pc_load    <= reset_req || (state_r == ST_RESUME && gie_r);       // R16 R17
         if (reset_req)
            pc_value <= PC_RESET;                                          // R4
         else if (state_r == ST_RESUME && gie_r)
            pc_value <= PC_VECTOR;                                         // R16
      end
   end
   // Without global interrupts pc_load stays low at resume so the core just
   // continues after the sleep instruction.

   assign port_dir_in = iodir_r;

   ////////////////////////////////////////////////////////////////////////////
   // Controlled registers and their reset values.

   // A write lands at the edge where the master sees waitrequest low.
   assign wr = avs_write && ack_r;
   assign rd = avs_read && !ack_r;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         memory_switch_reg_r <= ALL_ZERO;                                  // R8
      else if (wr && avs_address == ADDR_MEMSW)
         memory_switch_reg_r <= avs_writedata[7:0];
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         timer_ctrl_reg_r <= ALL_ZERO;
      else if (reset_req)
         timer_ctrl_reg_r <= timer_ctrl_reg_r & TIMER_KEEP_MSK;            // R9
      else if (wr && avs_address == ADDR_TIMER)
         timer_ctrl_reg_r <= avs_writedata[7:0];
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         irq_flag_r <= ALL_ZERO;
         wdt_ctrl_r <= ALL_ZERO;
         irq_en_r   <= ALL_ZERO;
      end
      else if (reset_req)
      begin
         irq_flag_r <= ALL_ZERO;                                           // R10
         wdt_ctrl_r <= ALL_ZERO;                                           // R10
         irq_en_r   <= ALL_ZERO;                                           // R10
      end
      else if (wr)
      begin
         if (avs_address == ADDR_IRQFLG) irq_flag_r <= avs_writedata[7:0];
         if (avs_address == ADDR_WDTCTL) wdt_ctrl_r <= avs_writedata[7:0];
         if (avs_address == ADDR_IRQEN)  irq_en_r   <= avs_writedata[7:0];
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         pull_high_ctrl_reg_r <= ALL_ONE;
         pull_down_ctrl_reg_r <= ALL_ONE;
         odrain_r             <= ALL_ONE;
         iodir_r              <= ALL_ONE;
      end
      else if (reset_req)
      begin
         pull_high_ctrl_reg_r <= ALL_ONE;                                  // R11
         pull_down_ctrl_reg_r <= ALL_ONE;                                  // R11
         odrain_r             <= ALL_ONE;                                  // R11
         iodir_r              <= ALL_ONE;                                  // R5
      end
      else if (wr)
      begin
         if (avs_address == ADDR_PULLHI) pull_high_ctrl_reg_r <= avs_writedata[7:0];
         if (avs_address == ADDR_PULLDN) pull_down_ctrl_reg_r <= avs_writedata[7:0];
         if (avs_address == ADDR_ODRAIN) odrain_r             <= avs_writedata[7:0];
         if (avs_address == ADDR_IODIR)  iodir_r              <= avs_writedata[7:0];
      end
   end

   // Control register; the watchdog enable drops on every reset.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         ctrl_r <= ALL_ZERO;
      else if (reset_req)
         ctrl_r <= ctrl_r & ~(8'h01 << CTL_WDT_EN);
      else if (wr && avs_address == ADDR_CTRL)
         ctrl_r <= avs_writedata[7:0];
   end

   ////////////////////////////////////////////////////////////////////////////
   // Avalon-MM answer: every access waits one cycle, then completes.

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         ack_r <= 1'b0;
      else
         ack_r <= (avs_read || avs_write) && !ack_r;
   end

   assign avs_waitrequest = (avs_read || avs_write) && !ack_r;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         avs_readdata <= BUS_UNMAPPED;
      else if (rd)
      begin
         case (avs_address)
            ADDR_CTRL:   avs_readdata <= {24'h00_0000, ctrl_r[7:4], gie_r, ctrl_r[2:0]};
            ADDR_STATUS: avs_readdata <= {27'h000_0000, state_r == ST_WAKE,
                                          core_reset, state_r == ST_SLEEP,
                                          pwrdn_flag_r, timeout_flag_r};
            ADDR_TIMER:  avs_readdata <= {24'h00_0000, timer_ctrl_reg_r};
            ADDR_MEMSW:  avs_readdata <= {24'h00_0000, memory_switch_reg_r};
            ADDR_IRQFLG: avs_readdata <= {24'h00_0000, irq_flag_r};
            ADDR_WDTCTL: avs_readdata <= {24'h00_0000, wdt_ctrl_r};
            ADDR_IRQEN:  avs_readdata <= {24'h00_0000, irq_en_r};
            ADDR_PULLHI: avs_readdata <= {24'h00_0000, pull_high_ctrl_reg_r};
            ADDR_PULLDN: avs_readdata <= {24'h00_0000, pull_down_ctrl_reg_r};
            ADDR_ODRAIN: avs_readdata <= {24'h00_0000, odrain_r};
            ADDR_IODIR:  avs_readdata <= {24'h00_0000, iodir_r};
            default:     avs_readdata <= BUS_UNMAPPED;
         endcase
      end
   end

endmodule : rws_sequencer
`default_nettype wire

//--- verif/rws_checker.sv
/*
 * Port checker for the reset and wake-up sequencer.
 * Assumes one clock domain; bound to every sequencer instance.
 */
`timescale 1ns/100ps
`default_nettype none
module rws_checker
   import rws_pkg::*;
#(
   parameter longint unsigned HOLD_NORMAL = 20,
   parameter longint unsigned HOLD_LXT    = 40
)
(
   // Clock and reset.
   input wire logic             clk,
   input wire logic             rst,
   // Sources and events.
   input wire logic             reset_pin_n,
   input wire logic             low_voltage,
   input wire logic             power_down_instr,
   // Core control.
   input wire logic             core_reset,
   input wire logic             osc_run,
   input wire logic             timer_run,
   input wire logic             wdt_clear,
   input wire logic             pc_load,
   input wire logic [PC_W-1:0]  pc_value,
   input wire logic [REG_W-1:0] port_dir_in,
   // Bus.
   input wire logic             avs_read,
   input wire logic             avs_write,
   input wire logic             avs_waitrequest
);
   longint unsigned hold_cnt_r;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         hold_cnt_r <= 0;
      else if (core_reset)
         hold_cnt_r <= hold_cnt_r + 1;
      else
         hold_cnt_r <= 0;
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   AST_PIN_RESET: assert property (!reset_pin_n |-> ##[1:2] core_reset)
      else $error("reset pin did not reset the core");
   AST_LV_RESET: assert property (low_voltage |-> ##[1:2] core_reset)
      else $error("low voltage did not reset the core");
   AST_HOLD_TIME: assert property ($fell(core_reset) |->
      hold_cnt_r + 2 >= HOLD_NORMAL && hold_cnt_r <= HOLD_LXT + 4)
      else $error("reset hold length out of range");
   AST_PC_ZERO: assert property (pc_load && core_reset |-> pc_value == PC_RESET)
      else $error("reset loaded a nonzero program counter");
   AST_PC_VECTOR: assert property (pc_load && !core_reset |-> pc_value == PC_VECTOR)
      else $error("wake resume loaded a wrong address");
   AST_PORTS_IN: assert property (core_reset && $past(core_reset) |->
      port_dir_in == ALL_ONE)
      else $error("port pins not inputs in reset");
   AST_RESET_OSC: assert property (core_reset && $past(core_reset) |->
      osc_run && !timer_run)
      else $error("oscillator stopped or timer running in reset");
   AST_WDT_CLEAR: assert property ($rose(core_reset) |-> ##[0:2] wdt_clear)
      else $error("watchdog not cleared on reset");
   AST_SLEEP_WDT: assert property (power_down_instr && timer_run |-> ##[1:2] wdt_clear)
      else $error("watchdog not cleared on sleep entry");
   AST_SLEEP_STOP: assert property (power_down_instr && timer_run && reset_pin_n
      && !low_voltage |-> ##[1:2] (!osc_run && !timer_run))
      else $error("sleep did not stop oscillator and timer");
   AST_BUS_ACK: assert property ($rose(avs_read || avs_write) |->
      avs_waitrequest ##1 !avs_waitrequest)
      else $error("bus answer not one cycle after request");

   COV_PIN: cover property (!reset_pin_n ##1 core_reset);
   COV_SLEEP: cover property (timer_run ##1 !osc_run);
   COV_VEC: cover property (pc_load && !core_reset);
endmodule : rws_checker

bind rws_sequencer rws_checker #(.HOLD_NORMAL(HOLD_NORMAL), .HOLD_LXT(HOLD_LXT)) rws_checker_i
(
   .clk(clk), .rst(rst), .reset_pin_n(reset_pin_n), .low_voltage(low_voltage),
   .power_down_instr(power_down_instr), .core_reset(core_reset), .osc_run(osc_run),
   .timer_run(timer_run), .wdt_clear(wdt_clear), .pc_load(pc_load), .pc_value(pc_value),
   .port_dir_in(port_dir_in), .avs_read(avs_read), .avs_write(avs_write),
   .avs_waitrequest(avs_waitrequest)
);
`default_nettype wire

//--- verif/rws_far_side.sv
/*
 * Model of the reset pin, reset and wake sources and firmware events.
 * Assumes tasks are called just after a rising clock edge.
 */
`timescale 1ns/100ps
`default_nettype none
module rws_far_side
(
   // Clock.
   input  wire logic clk,
   // Reset sources.
   output logic      reset_pin_n,
   output logic      low_voltage,
   output logic      wdt_timeout,
   // Firmware and wake events.
   output logic      power_down_instr,
   output logic      global_irq_on_instr,
   output logic      global_irq_off_instr,
   output logic      port_change,
   output logic      comparator_change
);
   logic [7:0] ev_r = 8'h00;

   assign reset_pin_n          = ~ev_r[0];
   assign low_voltage          = ev_r[1];
   assign wdt_timeout          = ev_r[2];
   assign power_down_instr     = ev_r[3];
   assign global_irq_on_instr  = ev_r[4];
   assign global_irq_off_instr = ev_r[5];
   assign port_change          = ev_r[6];
   assign comparator_change    = ev_r[7];

   // One event for one clock cycle.
   task automatic pulse(input int k);
      ev_r[k] <= 1'b1;
      @(posedge clk);
      ev_r[k] <= 1'b0;
   endtask : pulse
endmodule : rws_far_side
`default_nettype wire

//--- verif/rws_sequencer_tb.sv
/*
 * Self-checking bench for the reset and wake-up sequencer.
 * Assumes the far-side model and the bound checker are compiled with it.
 */
`timescale 1ns/100ps
`default_nettype none
module rws_sequencer_tb;
   import rws_pkg::*;
   localparam int HN = 20;
   localparam int HL = 40;
   localparam int WK [3] = '{5, 10, 30};
   localparam int PIN = 0, LV = 1, WTO = 2, SLP = 3, GON = 4, GOFF = 5, PCH = 6, CCH = 7;
   localparam logic [7:0] RA [10] = '{ADDR_TIMER, ADDR_MEMSW, ADDR_IRQFLG, ADDR_WDTCTL,
      ADDR_IRQEN, ADDR_PULLHI, ADDR_PULLDN, ADDR_ODRAIN, ADDR_IODIR, 8'h30};
   localparam logic [31:0] RV [10] = '{0, 0, 0, 0, 0, 'hFF, 'hFF, 'hFF, 'hFF, 0};

   logic             clk, rst, rd, wr, core_reset, osc_run, timer_run, pc_load, wait_r;
   wire logic        pin_n, lv, wto, pdi, gon, goff, pch, cch;
   logic [PC_W-1:0]  pc_value;
   logic [REG_W-1:0] port_dir_in;
   logic [7:0]       adr;
   logic [31:0]      wd, rdata, e, seed, v [10];
   logic [31:0]      rq [$], mq [$];
   logic [PC_W-1:0]  pq [$];
   int               bad_count, tests_run;

   rws_far_side far_i (.clk(clk), .reset_pin_n(pin_n), .low_voltage(lv), .wdt_timeout(wto),
      .power_down_instr(pdi), .global_irq_on_instr(gon), .global_irq_off_instr(goff),
      .port_change(pch), .comparator_change(cch));

   rws_sequencer #(.HOLD_NORMAL(HN), .HOLD_LXT(HL), .WAKE_RC(WK[0]), .WAKE_HXT(WK[1]),
      .WAKE_LXT(WK[2])) rws_sequencer_i (.clk(clk), .rst(rst), .reset_pin_n(pin_n),
      .low_voltage(lv), .wdt_timeout(wto), .power_down_instr(pdi),
      .global_irq_on_instr(gon), .global_irq_off_instr(goff), .port_change(pch),
      .comparator_change(cch), .core_reset(core_reset), .osc_run(osc_run),
      .timer_run(timer_run), .wdt_clear(), .pc_load(pc_load), .pc_value(pc_value),
      .port_dir_in(port_dir_in), .avs_address(adr), .avs_read(rd), .avs_write(wr),
      .avs_writedata(wd), .avs_readdata(rdata), .avs_waitrequest(wait_r));

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         bad_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic test_done();
      if (bad_count == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : test_done

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      rd  <= !w;
      wr  <= w;
      adr <= a;
      wd  <= d;
      do
         @(posedge clk);
      while (wait_r !== 1'b0);
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge clk);
   endtask : bus

   task automatic rdx(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m);
      rq.push_back(x & m);
      mq.push_back(m);
      bus(1'b0, a, 32'h0000_0000);
   endtask : rdx

   task automatic hold_len(input int h);
      int n;
      n = 0;
      // The reset shows on core_reset only after the edge that takes it.
      do
      begin
         @(posedge clk);
         n++;
      end
      while (core_reset !== 1'b0 && n < 999);
      chk(n >= h - 2 && n <= h + 3, 1);
   endtask : hold_len

   task automatic wake_len(input int k, input int w);
      int n;
      n = 0;
      far_i.pulse(k);
      while (timer_run !== 1'b1 && n < 999)
      begin
         @(posedge clk);
         n++;
      end
      chk(n >= w && n <= w + 5, 1);
   endtask : wake_len

   // Firmware preparation: watchdog off, interrupt state, wake enable, sleep.
   task automatic fw_sleep(input int m, input logic gie, input logic [2:0] en);
      bus(1'b1, ADDR_CTRL, {26'd0, m[1:0], 4'h0});
      far_i.pulse(gie ? GON : GOFF);
      bus(1'b1, ADDR_CTRL, {26'd0, m[1:0], gie, en});
      far_i.pulse(SLP);
      repeat (3) @(posedge clk);
      chk({osc_run, timer_run}, 0);
   endtask : fw_sleep

   always @(posedge clk)
   begin
      if (rd && wait_r === 1'b0 && rq.size() > 0)
         chk(rdata & mq.pop_front(), rq.pop_front());
      if (pc_load === 1'b1 && core_reset === 1'b0)
         chk(pc_value, pq.size() > 0 ? pq.pop_front() : 11'h7FF);
   end

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   initial
   begin
      #200_000;
      bad_count++;
      test_done();
   end

   initial
   begin
      rst = 1'b1;
      rd = 1'b0;
      wr = 1'b0;
      adr = 8'h00;
      wd = 32'h0000_0000;
      seed = 32'd83627;
      bad_count = 0;
      tests_run = 0;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      hold_len(HN);
      for (int p = 0; p < 3; p++)
      begin
         if (p == 2)
         begin
            far_i.pulse(PIN);
            hold_len(HN);
         end
         for (int i = 0; i < 10; i++)
         begin
            if (p == 1)
            begin
               v[i] = rnd();
               bus(1'b1, RA[i], v[i]);
            end
            e = (p == 1 && i < 9) || (p == 2 && i == 1) ? {24'd0, v[i][7:0]} : RV[i];
            rdx(RA[i], e, i == 0 ? 32'hFFFF_FFBF : 32'hFFFF_FFFF);
         end
      end
      rdx(ADDR_STATUS, 0, 1);
      for (int m = 0; m < 3; m++)
      begin
         fw_sleep(m, m != 1, m == 1 ? 3'b100 : 3'b010);
         if (m != 1)
            pq.push_back(PC_VECTOR);
         wake_len(m == 1 ? CCH : PCH, WK[m]);
      end
      fw_sleep(2, 1'b0, 3'b011);
      far_i.pulse(PCH);
      repeat (40) @(posedge clk);
      chk({osc_run, timer_run}, 0);
      far_i.pulse(WTO);
      hold_len(HL);
      rdx(ADDR_STATUS, 3, 3);
      fw_sleep(0, 1'b0, 3'b000);
      far_i.pulse(LV);
      hold_len(HN);
      fw_sleep(0, 1'b0, 3'b000);
      far_i.pulse(PIN);
      hold_len(HN);
      rdx(ADDR_STATUS, 2, 3);
      test_done();
   end
endmodule : rws_sequencer_tb
`default_nettype wire
